// file: hdl/pll_ch1_status_pkg.sv
// Register map, field positions and reset values for the loop 1 status readback bank
package pll_ch1_status_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PROFILE_W = 3;
    localparam int unsigned HISTORY_W = 46;

    localparam logic [15:0] ADDR_OPERATION = 16'h3201;
    localparam logic [15:0] ADDR_STATE     = 16'h3202;
    localparam logic [15:0] ADDR_HIST0     = 16'h3203;
    localparam logic [15:0] ADDR_HIST1     = 16'h3204;
    localparam logic [15:0] ADDR_HIST2     = 16'h3205;
    localparam logic [15:0] ADDR_HIST3     = 16'h3206;
    localparam logic [15:0] ADDR_HIST4     = 16'h3207;
    localparam logic [15:0] ADDR_HIST5     = 16'h3208;
    localparam logic [15:0] ADDR_CONTROL   = 16'h3210;

    // Operation register fields
    localparam int unsigned OP_PROFILE_LSB  = 4;
    localparam int unsigned OP_ACTIVE_BIT   = 3;
    localparam int unsigned OP_SWITCH_BIT   = 2;
    localparam int unsigned OP_HOLDOVER_BIT = 1;
    localparam int unsigned OP_FREERUN_BIT  = 0;

    // State register fields
    localparam int unsigned ST_FAST_ACQUISITION_DONE_BIT   = 5;
    localparam int unsigned ST_FAST_ACQUISITION_ACTIVE_BIT = 4;
    localparam int unsigned ST_SLEW_BIT        = 2;
    localparam int unsigned ST_CLAMP_BIT       = 1;
    localparam int unsigned ST_HISTORY_BIT     = 0;

    // Control register fields (write only, self clearing)
    localparam int unsigned CTL_FAST_ACQUISITION_CLEAR_BIT = 0;
    localparam int unsigned CTL_UPDATE_BIT     = 1;

    localparam int unsigned HIST5_BITS = 6;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] RESET_PROFILE = 3'h0;
endpackage : pll_ch1_status_pkg

// file: hdl/status_snap_if.sv
// Carrier between the live status capture and the register bank
`timescale 1ns/1ps
interface status_snap_if;
    logic        update;
    logic [2:0]  profile;
    logic        active;
    logic        switching;
    logic        holdover;
    logic        freerun;
    logic        fast_acquisition_done;
    logic        fast_acquisition_active;
    logic        slew;
    logic        clamp;
    logic        hist_valid;
    logic [45:0] history;

    modport capture (input update, output profile, active, switching, holdover, freerun,
                     fast_acquisition_done, fast_acquisition_active, slew, clamp, hist_valid, history);
    modport bank    (output update, input profile, active, switching, holdover, freerun,
                     fast_acquisition_done, fast_acquisition_active, slew, clamp, hist_valid, history);
endinterface : status_snap_if

// file: hdl/status_live_track.sv
// Live loop state tracking: last profile and sticky fast-acquisition done
`timescale 1ns/1ps
module status_live_track (
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic [2:0]  i_profile,
    input  wire logic        i_active,
    input  wire logic        i_fast_acquisition_done_evt,
    input  wire logic        i_fast_acquisition_clear,
    output logic [2:0]       o_profile,
    output logic             o_fast_acquisition_done
);
    logic [2:0] profile_r;
    logic       fast_acquisition_done_r;

    // Hold last profile while the loop is idle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            profile_r <= pll_ch1_status_pkg::RESET_PROFILE;
        end else if (i_active) begin
            profile_r <= i_profile;
        end
    end

    // Set beats clear so a completion in the clear cycle is kept
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fast_acquisition_done_r <= 1'b0;
        end else if (i_fast_acquisition_done_evt) begin
            fast_acquisition_done_r <= 1'b1;
        end else if (i_fast_acquisition_clear) begin
            fast_acquisition_done_r <= 1'b0;
        end
    end

    assign o_profile   = i_active ? i_profile : profile_r;
    assign o_fast_acquisition_done = fast_acquisition_done_r;
endmodule : status_live_track

// file: hdl/pll_ch1_status_readback.sv
// Loop 1 status readback bank: snapshot on update, byte-wide register reads
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module pll_ch1_status_readback #(
    parameter int unsigned HISTORY_W = pll_ch1_status_pkg::HISTORY_W
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_srst,
    input  wire logic [15:0]           i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [7:0]                 o_rdata,
    input  wire logic                  i_io_update,
    input  wire logic [2:0]            i_profile,
    input  wire logic                  i_active,
    input  wire logic                  i_switching,
    input  wire logic                  i_holdover,
    input  wire logic                  i_freerun,
    input  wire logic                  i_fast_acquisition_done_evt,
    input  wire logic                  i_fast_acquisition_active,
    input  wire logic                  i_slew_limit,
    input  wire logic                  i_freq_clamp,
    input  wire logic                  i_hist_valid,
    input  wire logic [HISTORY_W-1:0]  i_history
);
    status_snap_if snap ();

    logic        ctl_wr;
    logic        fast_acquisition_clear;
    logic        sw_update;
    logic        update;

    logic [2:0]  profile_r;
    logic        active_r;
    logic        switching_r;
    logic        holdover_r;
    logic        freerun_r;
    logic        fast_acquisition_done_r;
    logic        fast_acquisition_active_r;
    logic        slew_r;
    logic        clamp_r;
    logic        hist_valid_r;
    logic [45:0] history_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic [7:0]  op_byte;
    logic [7:0]  st_byte;

    // Only the control word accepts writes; status bytes drop them
    assign ctl_wr     = i_wr && (i_addr == pll_ch1_status_pkg::ADDR_CONTROL);
    assign fast_acquisition_clear = ctl_wr && i_wdata[pll_ch1_status_pkg::CTL_FAST_ACQUISITION_CLEAR_BIT];
    assign sw_update  = ctl_wr && i_wdata[pll_ch1_status_pkg::CTL_UPDATE_BIT];
    assign update     = i_io_update || sw_update;
    assign snap.update = update;

    status_live_track u_live (
        .i_clock         (i_clock),
        .i_srst          (i_srst),
        .i_profile       (i_profile),
        .i_active        (i_active),
        .i_fast_acquisition_done_evt (i_fast_acquisition_done_evt),
        .i_fast_acquisition_clear    (fast_acquisition_clear),
        .o_profile       (snap.profile),
        .o_fast_acquisition_done     (snap.fast_acquisition_done)
    );

    assign snap.active      = i_active;
    assign snap.switching   = i_switching;
    assign snap.holdover    = i_holdover;
    assign snap.freerun     = i_freerun;
    assign snap.fast_acquisition_active = i_fast_acquisition_active;
    assign snap.slew        = i_slew_limit;
    assign snap.clamp       = i_freq_clamp;
    assign snap.hist_valid  = i_hist_valid;
    assign snap.history     = i_history[45:0];

    // Snapshot of operation fields on update
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            profile_r   <= pll_ch1_status_pkg::RESET_PROFILE;
            active_r    <= 1'b0;
            switching_r <= 1'b0;
            holdover_r  <= 1'b0;
            freerun_r   <= 1'b0;
        end else if (snap.update) begin
            profile_r   <= snap.profile;
            active_r    <= snap.active;
            switching_r <= snap.switching;
            holdover_r  <= snap.holdover;
            freerun_r   <= snap.freerun;
        end
    end

    // Snapshot of loop state flags on update
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fast_acquisition_done_r   <= 1'b0;
            fast_acquisition_active_r <= 1'b0;
            slew_r        <= 1'b0;
            clamp_r       <= 1'b0;
            hist_valid_r  <= 1'b0;
        end else if (snap.update) begin
            fast_acquisition_done_r   <= snap.fast_acquisition_done;
            fast_acquisition_active_r <= snap.fast_acquisition_active;
            slew_r        <= snap.slew;
            clamp_r       <= snap.clamp;
            hist_valid_r  <= snap.hist_valid;
        end
    end

    // Whole history word captured at once so multi-byte reads stay coherent
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            history_r <= '0;
        end else if (snap.update) begin
            history_r <= snap.history;
        end
    end

    always_comb begin
        op_byte = pll_ch1_status_pkg::RESET_BYTE;
        op_byte[pll_ch1_status_pkg::OP_PROFILE_LSB +: 3] = profile_r;
        op_byte[pll_ch1_status_pkg::OP_ACTIVE_BIT]       = active_r;
        op_byte[pll_ch1_status_pkg::OP_SWITCH_BIT]       = switching_r;
        op_byte[pll_ch1_status_pkg::OP_HOLDOVER_BIT]     = holdover_r;
        op_byte[pll_ch1_status_pkg::OP_FREERUN_BIT]      = freerun_r;
    end

    always_comb begin
        st_byte = pll_ch1_status_pkg::RESET_BYTE;
        st_byte[pll_ch1_status_pkg::ST_FAST_ACQUISITION_DONE_BIT]   = fast_acquisition_done_r;
        st_byte[pll_ch1_status_pkg::ST_FAST_ACQUISITION_ACTIVE_BIT] = fast_acquisition_active_r;
        st_byte[pll_ch1_status_pkg::ST_SLEW_BIT]        = slew_r;
        st_byte[pll_ch1_status_pkg::ST_CLAMP_BIT]       = clamp_r;
        st_byte[pll_ch1_status_pkg::ST_HISTORY_BIT]     = hist_valid_r;
    end

    // Unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_nxt = pll_ch1_status_pkg::RESET_BYTE;
        case (i_addr)
            pll_ch1_status_pkg::ADDR_OPERATION: rdata_nxt = op_byte;
            pll_ch1_status_pkg::ADDR_STATE:     rdata_nxt = st_byte;
            pll_ch1_status_pkg::ADDR_HIST0:     rdata_nxt = history_r[7:0];
            pll_ch1_status_pkg::ADDR_HIST1:     rdata_nxt = history_r[15:8];
            pll_ch1_status_pkg::ADDR_HIST2:     rdata_nxt = history_r[23:16];
            pll_ch1_status_pkg::ADDR_HIST3:     rdata_nxt = history_r[31:24];
            pll_ch1_status_pkg::ADDR_HIST4:     rdata_nxt = history_r[39:32];
            pll_ch1_status_pkg::ADDR_HIST5:     rdata_nxt = {2'h0, history_r[45:40]};
            default:                            rdata_nxt = pll_ch1_status_pkg::RESET_BYTE;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rdata_r <= pll_ch1_status_pkg::RESET_BYTE;
        end else if (i_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= pll_ch1_status_pkg::RESET_BYTE;
        end
    end

    assign o_rdata = rdata_r;

    property p_profile_snap;
        @(posedge i_clock) disable iff (i_srst)
        (update && i_active) |=> (profile_r == $past(i_profile));
    endproperty
    a_profile_snap: assert property (p_profile_snap)
        else $error("profile not captured");

    property p_profile_hold;
        @(posedge i_clock) disable iff (i_srst)
        (update && !i_active) |=> (profile_r == $past(snap.profile));
    endproperty
    a_profile_hold: assert property (p_profile_hold)
        else $error("idle profile wrong");

    // Read data reflect the snapshot as it stood at the strobe edge
    property p_op_read;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && i_addr == pll_ch1_status_pkg::ADDR_OPERATION)
        |=> (o_rdata[3:0] == $past({active_r, switching_r, holdover_r, freerun_r}))
            && !o_rdata[7];
    endproperty
    a_op_read: assert property (p_op_read)
        else $error("operation byte wrong");

    property p_mode_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (switching_r == $past(i_switching)) && (holdover_r == $past(i_holdover))
                   && (freerun_r == $past(i_freerun));
    endproperty
    a_mode_snap: assert property (p_mode_snap)
        else $error("mode flags not captured");

    property p_stable_no_update;
        @(posedge i_clock) disable iff (i_srst)
        (!update && !$past(i_srst)) |=> $stable(history_r) && $stable(op_byte) && $stable(st_byte);
    endproperty
    a_stable_no_update: assert property (p_stable_no_update)
        else $error("snapshot moved");

    property p_fast_acquisition_set;
        @(posedge i_clock) disable iff (i_srst)
        i_fast_acquisition_done_evt ##1 update |=> fast_acquisition_done_r;
    endproperty
    a_fast_acquisition_set: assert property (p_fast_acquisition_set)
        else $error("fast_acquisition done lost");

    property p_state_read;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && i_addr == pll_ch1_status_pkg::ADDR_STATE)
        |=> (o_rdata == $past({2'h0, fast_acquisition_done_r, fast_acquisition_active_r, 1'b0,
                               slew_r, clamp_r, hist_valid_r}));
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("state byte wrong");

    property p_hist_read;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && i_addr == pll_ch1_status_pkg::ADDR_HIST3)
        |=> (o_rdata == $past(history_r[31:24]));
    endproperty
    a_hist_read: assert property (p_hist_read)
        else $error("history byte wrong");

    property p_hist5_read;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && i_addr == pll_ch1_status_pkg::ADDR_HIST5)
        |=> (o_rdata == $past({2'h0, history_r[45:40]}));
    endproperty
    a_hist5_read: assert property (p_hist5_read)
        else $error("top history byte wrong");

    property p_no_read_zero;
        @(posedge i_clock) disable iff (i_srst)
        !i_rd |=> (o_rdata == 8'h00);
    endproperty
    a_no_read_zero: assert property (p_no_read_zero)
        else $error("read data outside slot");

    property p_active_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (active_r == $past(i_active));
    endproperty
    a_active_snap: assert property (p_active_snap)
        else $error("active flag not captured");

    property p_switch_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (switching_r == $past(i_switching));
    endproperty
    a_switch_snap: assert property (p_switch_snap)
        else $error("switching flag not captured");

    property p_freerun_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (freerun_r == $past(i_freerun));
    endproperty
    a_freerun_snap: assert property (p_freerun_snap)
        else $error("free-run flag not captured");

    property p_fast_acquisition_active_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (fast_acquisition_active_r == $past(i_fast_acquisition_active));
    endproperty
    a_fast_acquisition_active_snap: assert property (p_fast_acquisition_active_snap)
        else $error("fast_acquisition active not captured");

    property p_slew_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (slew_r == $past(i_slew_limit));
    endproperty
    a_slew_snap: assert property (p_slew_snap)
        else $error("slew flag not captured");

    property p_clamp_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (clamp_r == $past(i_freq_clamp));
    endproperty
    a_clamp_snap: assert property (p_clamp_snap)
        else $error("clamp flag not captured");

    property p_hist_valid_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (hist_valid_r == $past(i_hist_valid));
    endproperty
    a_hist_valid_snap: assert property (p_hist_valid_snap)
        else $error("history valid not captured");

    property p_history_snap;
        @(posedge i_clock) disable iff (i_srst)
        update |=> (history_r == $past(i_history[45:0]));
    endproperty
    a_history_snap: assert property (p_history_snap)
        else $error("history word not captured");

    // Idle loop must not disturb the held profile
    property p_profile_idle;
        @(posedge i_clock) disable iff (i_srst)
        (!i_active ##1 !i_active) |-> $stable(snap.profile);
    endproperty
    a_profile_idle: assert property (p_profile_idle)
        else $error("held profile moved");

    property p_fast_acquisition_sticky;
        @(posedge i_clock) disable iff (i_srst)
        (snap.fast_acquisition_done && !fast_acquisition_clear) |=> snap.fast_acquisition_done;
    endproperty
    a_fast_acquisition_sticky: assert property (p_fast_acquisition_sticky)
        else $error("done flag dropped without clear");

    property p_fast_acquisition_clear;
        @(posedge i_clock) disable iff (i_srst)
        (fast_acquisition_clear && !i_fast_acquisition_done_evt) |=> !snap.fast_acquisition_done;
    endproperty
    a_fast_acquisition_clear: assert property (p_fast_acquisition_clear)
        else $error("done flag not cleared");

    property p_hist0_read;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && i_addr == pll_ch1_status_pkg::ADDR_HIST0)
        |=> (o_rdata == $past(history_r[7:0]));
    endproperty
    a_hist0_read: assert property (p_hist0_read)
        else $error("low history byte wrong");

    property p_unmapped_read;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && (i_addr < pll_ch1_status_pkg::ADDR_OPERATION
                  || i_addr > pll_ch1_status_pkg::ADDR_HIST5))
        |=> (o_rdata == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");
endmodule : pll_ch1_status_readback

// file: test/test_pll_ch1_status_readback.sv
// Self-checking testbench for the loop 1 status readback bank
`timescale 1ns/1ps
module test_pll_ch1_status_readback;
    // Live flags in lv: active, switching, holdover, freerun, fast_acquisition active, slew, clamp, hist valid
    typedef struct packed {
        logic [2:0]  prof;
        logic [7:0]  lv;
        logic [45:0] hist;
        logic [7:0]  exp_op;
        logic [7:0]  exp_st;
    } row_s;

    logic        i_clock = 1'b0;
    logic        i_srst = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  o_rdata;
    logic        i_io_update = 1'b0;
    logic [2:0]  i_profile = 3'h0;
    logic        i_active = 1'b0;
    logic        i_switching = 1'b0;
    logic        i_holdover = 1'b0;
    logic        i_freerun = 1'b0;
    logic        i_fast_acquisition_done_evt = 1'b0;
    logic        i_fast_acquisition_active = 1'b0;
    logic        i_slew_limit = 1'b0;
    logic        i_freq_clamp = 1'b0;
    logic        i_hist_valid = 1'b0;
    logic [45:0] i_history = 46'h0;
    int          n_errors = 0;
    int          n_compared = 0;
    row_s        rows [5];

    always #2 i_clock = ~i_clock;

    pll_ch1_status_readback dut (
        .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_io_update(i_io_update),
        .i_profile(i_profile), .i_active(i_active), .i_switching(i_switching),
        .i_holdover(i_holdover), .i_freerun(i_freerun), .i_fast_acquisition_done_evt(i_fast_acquisition_done_evt),
        .i_fast_acquisition_active(i_fast_acquisition_active), .i_slew_limit(i_slew_limit),
        .i_freq_clamp(i_freq_clamp), .i_hist_valid(i_hist_valid), .i_history(i_history)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s read %h, expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp, $sformatf("address %h", a));
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr

    task automatic upd();
        @(posedge i_clock);
        i_io_update <= 1'b1;
        @(posedge i_clock);
        i_io_update <= 1'b0;
    endtask : upd

    // Extra idle cycle lets the profile hold and sticky flag settle before a snapshot
    task automatic set_live(input row_s r, input bit snap);
        @(posedge i_clock);
        i_profile <= r.prof;
        {i_active, i_switching, i_holdover, i_freerun} <= r.lv[7:4];
        {i_fast_acquisition_active, i_slew_limit, i_freq_clamp, i_hist_valid} <= r.lv[3:0];
        i_history <= r.hist;
        @(posedge i_clock);
        if (snap) begin
            upd();
        end
    endtask : set_live

    task automatic pulse_done();
        @(posedge i_clock);
        i_fast_acquisition_done_evt <= 1'b1;
        @(posedge i_clock);
        i_fast_acquisition_done_evt <= 1'b0;
        @(posedge i_clock);
    endtask : pulse_done

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        $display("Error at %0t: run did not finish in time", $time);
        close_out();
    end

    initial begin
        rows[0] = '{3'h5, 8'h89, 46'h3a5c_1234_5678, 8'h58, 8'h11};
        rows[1] = '{3'h2, 8'h44, 46'h0000_0000_0000, 8'h54, 8'h04};
        rows[2] = '{3'h7, 8'h23, 46'h3fff_ffff_ffff, 8'h52, 8'h03};
        rows[3] = '{3'h0, 8'h80, 46'h2bcd_8765_4321, 8'h08, 8'h00};
        rows[4] = '{3'h3, 8'h10, 46'h2bcd_8765_4321, 8'h01, 8'h00};
        @(posedge i_clock);
        @(posedge i_clock);
        i_srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            set_live(rows[i], 1'b1);
            rd(pll_ch1_status_pkg::ADDR_OPERATION, rows[i].exp_op);
            rd(pll_ch1_status_pkg::ADDR_STATE, rows[i].exp_st);
            for (int k = 0; k < 6; k++) begin
                rd(pll_ch1_status_pkg::ADDR_HIST0 + 16'(k), (k < 5) ? rows[i].hist[8*k +: 8]
                   : {2'b00, rows[i].hist[45:40]});
            end
        end
        // Live change without a snapshot must not show
        set_live(rows[0], 1'b0);
        rd(pll_ch1_status_pkg::ADDR_OPERATION, 8'h01);
        @(posedge i_clock);
        #1;
        chk(o_rdata, 8'h00, "idle read data");
        // Writes to status bytes are dropped; unmapped and control reads give zero
        wr(pll_ch1_status_pkg::ADDR_OPERATION, 8'hff);
        wr(pll_ch1_status_pkg::ADDR_HIST3, 8'hff);
        rd(pll_ch1_status_pkg::ADDR_OPERATION, 8'h01);
        upd();
        rd(pll_ch1_status_pkg::ADDR_OPERATION, 8'h58);
        rd(pll_ch1_status_pkg::ADDR_HIST3, 8'h12);
        rd(16'h3209, 8'h00);
        rd(pll_ch1_status_pkg::ADDR_CONTROL, 8'h00);
        // Sticky fast acquisition done, cleared only by the control write
        set_live('0, 1'b0);
        pulse_done();
        upd();
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h20);
        upd();
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h20);
        wr(pll_ch1_status_pkg::ADDR_CONTROL, 8'h01);
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h20);
        upd();
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h00);
        pulse_done();
        wr(pll_ch1_status_pkg::ADDR_CONTROL, 8'h02);
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h20);
        // Clear with snapshot in one write: snapshot sees the flag before clearing
        wr(pll_ch1_status_pkg::ADDR_CONTROL, 8'h03);
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h20);
        upd();
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h00);
        // Completion and clear on the same edge: completion wins
        fork
            pulse_done();
            wr(pll_ch1_status_pkg::ADDR_CONTROL, 8'h01);
        join
        upd();
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h20);
        // Reset in mid-run clears snapshots and the held profile
        set_live(rows[0], 1'b1);
        @(posedge i_clock);
        i_srst <= 1'b1;
        // Loop idle from reset on, else the held profile relearns
        i_active <= 1'b0;
        @(posedge i_clock);
        @(posedge i_clock);
        i_srst <= 1'b0;
        rd(pll_ch1_status_pkg::ADDR_OPERATION, 8'h00);
        rd(pll_ch1_status_pkg::ADDR_STATE, 8'h00);
        rd(pll_ch1_status_pkg::ADDR_HIST0, 8'h00);
        set_live('{3'h6, 8'h00, 46'h0, 8'h00, 8'h00}, 1'b1);
        rd(pll_ch1_status_pkg::ADDR_OPERATION, 8'h00);
        close_out();
    end
endmodule : test_pll_ch1_status_readback
